// ==== ddl_top.sv ====
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps

// What this block does
// - Shift serial_in on serial clock rise, frame low.
// - Serial pin feeds shift chain with no stage.
// - Frame select high freezes the shift register.
// - Frame rise copies code to addressed input register.
// - Preset forces all registers to zero or midscale.
// - Power-on loads the same preset-level value.
// - Load strobe low makes DAC registers follow inputs.
// - Load strobe works independent of framing activity.
// - Sixteen-bit word, MSB first, address on top.
// - Only the last sixteen shifted bits are used.
// - Address bits of the word pick the destination.
// - Preset acts without any serial clock edge.
module ddl_top #(
  parameter int ADDR_W = 8
) (
  // Clocks and reset.
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_sclk,
  // Serial link pins.
  input  wire logic                       i_serial_in,
  input  wire logic                       i_frame_sel_n,
  // Converter control pins.
  input  wire logic                       i_preset_n,
  input  wire logic                       i_preset_level,
  input  wire logic                       i_dac_load_n,
  // Converter codes towards the ladders.
  output logic [ddl_pkg::CODE_W-1:0]      o_dac_a,
  output logic [ddl_pkg::CODE_W-1:0]      o_dac_b,
  // AXI4-Lite write address channel.
  input  wire logic                       i_awvalid,
  output logic                            o_awready,
  input  wire logic [ADDR_W-1:0]          i_awaddr,
  // AXI4-Lite write data channel.
  input  wire logic                       i_wvalid,
  output logic                            o_wready,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  // AXI4-Lite write response channel.
  output logic                            o_bvalid,
  input  wire logic                       i_bready,
  output logic [1:0]                      o_bresp,
  // AXI4-Lite read address channel.
  input  wire logic                       i_arvalid,
  output logic                            o_arready,
  input  wire logic [ADDR_W-1:0]          i_araddr,
  // AXI4-Lite read data channel.
  output logic                            o_rvalid,
  input  wire logic                       i_rready,
  output logic [31:0]                     o_rdata,
  output logic [1:0]                      o_rresp
);
  import ddl_pkg::*;

  // The decoder compares the low offset bits and needs the upper bits to be zero.
  if (ADDR_W < REG_AW || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between REG_AW and 32.");
  end

  // True when a bus address selects the register at the given offset.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    reg_hit = (a[REG_AW-1:0] == off[REG_AW-1:0]) && (a >> REG_AW) == '0;
  endfunction

  // True when a frame address code selects the given channel.
  function automatic logic chan_sel(input logic [1:0] code, input logic [1:0] ch);
    chan_sel = (code == ch) || (code == CH_BOTH);
  endfunction

  // Link domain: the shift chain clocked by the serial clock.
  logic [WORD_W-1:0] sr_q;                  // Serial shift register, last bit in at bit 0.

  // The pin is shifted in at the very edge it is sampled on; framing comes from the
  // same master as the clock, so frame select is used here without a synchroniser.
  always_ff @(posedge i_sclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sr_q <= '0;
    end else if (!i_frame_sel_n) begin // Frame select high leaves the chain frozen.
      sr_q <= {sr_q[WORD_W-2:0], i_serial_in};
    end
  end

  // System domain synchronisers for the pins.
  logic cs_s1_q, cs_s2_q, cs_s3_q;          // Frame select stages plus edge history.
  logic pre_s1_q, pre_s2_q;                 // Preset pin stages.
  logic lvl_s1_q, lvl_s2_q;                 // Preset-level pin stages.
  logic ld_s1_q, ld_s2_q;                   // Load strobe stages.
  logic [1:0] init_cnt_q;                   // Power-on preset countdown.

  // Frame select resets high so that release is never mistaken for a frame end.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      pre_s1_q <= 1'b0;
      pre_s2_q <= 1'b0;
      lvl_s1_q <= 1'b0;
      lvl_s2_q <= 1'b0;
      ld_s1_q  <= 1'b1;
      ld_s2_q  <= 1'b1;
    end else begin
      cs_s1_q  <= i_frame_sel_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      pre_s1_q <= i_preset_n;
      pre_s2_q <= pre_s1_q;
      lvl_s1_q <= i_preset_level;
      lvl_s2_q <= lvl_s1_q;
      ld_s1_q  <= i_dac_load_n;
      ld_s2_q  <= ld_s1_q;
    end
  end

  // The preset level cannot be caught under reset, so preset is held for a few cycles
  // after release until the level synchroniser carries the real pin value.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      init_cnt_q <= INIT_CYC;
    end else if (init_cnt_q != 2'h0) begin
      init_cnt_q <= init_cnt_q - 2'h1;
    end
  end

  // Control and status state.
  logic [1:0]           ctrl_q;             // Capture enable and software preset.
  logic [FRM_CNT_W-1:0] frm_cnt_q;          // Count of accepted frames, wraps.
  logic [1:0]           last_addr_q;        // Address code of the last accepted frame.

  // Decoded frame and control terms.
  wire       frm_end    = cs_s2_q & ~cs_s3_q;
  wire       frm_take   = frm_end & ctrl_q[CTRL_CAP_EN_BIT];
  wire [1:0] frm_addr   = {sr_q[ADDR_HI_BIT], sr_q[ADDR_LO_BIT]};
  wire [CODE_W-1:0] frm_code = sr_q[CODE_W-1:0];
  wire       preset_act = ~pre_s2_q | ctrl_q[CTRL_PRESET_BIT] | (init_cnt_q != 2'h0);
  wire       load_act   = ~ld_s2_q;
  wire [CODE_W-1:0] preset_val = lvl_s2_q ? PRESET_MID : PRESET_ZERO;
  // The shift chain is frozen while frame select is high, so reading it two cycles after
  // the rise is safe; the master must keep frame select high at least four clock cycles.
  wire       wr_a = frm_take & chan_sel(frm_addr, CH_A);
  wire       wr_b = frm_take & chan_sel(frm_addr, CH_B);

  // Converter registers.
  logic [CODE_W-1:0] in_a_q, in_b_q, dac_a_q, dac_b_q;

  // Preset outranks the frame transfer and the load strobe.
  wire [CODE_W-1:0] in_a_d  = preset_act ? preset_val : (wr_a ? frm_code : in_a_q);
  wire [CODE_W-1:0] in_b_d  = preset_act ? preset_val : (wr_b ? frm_code : in_b_q);
  wire [CODE_W-1:0] dac_a_d = preset_act ? preset_val : (load_act ? in_a_q : dac_a_q);
  wire [CODE_W-1:0] dac_b_d = preset_act ? preset_val : (load_act ? in_b_q : dac_b_q);

  // Register update; preset rides the synchronised pin and needs no serial clock.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      in_a_q  <= PRESET_ZERO;
      in_b_q  <= PRESET_ZERO;
      dac_a_q <= PRESET_ZERO;
      dac_b_q <= PRESET_ZERO;
    end else begin
      in_a_q  <= in_a_d;
      in_b_q  <= in_b_d;
      dac_a_q <= dac_a_d;
      dac_b_q <= dac_b_d;
    end
  end

  assign o_dac_a = dac_a_q;
  assign o_dac_b = dac_b_q;

  // Bus write path state.
  logic              aw_rdy_q, w_rdy_q, aw_have_q, w_have_q, bvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic [1:0]        bresp_q;

  // Address and data are held independently; the write happens once both are in.
  wire aw_fire   = i_awvalid & aw_rdy_q;
  wire w_fire    = i_wvalid & w_rdy_q;
  wire do_write  = aw_have_q & w_have_q;
  wire aw_have_d = (aw_have_q | aw_fire) & ~do_write;
  wire w_have_d  = (w_have_q | w_fire) & ~do_write;
  wire bvalid_d  = do_write | (bvalid_q & ~i_bready);
  wire wr_ctrl   = reg_hit(aw_addr_q, REG_CTRL);
  wire wr_known  = wr_ctrl | reg_hit(aw_addr_q, REG_STATUS) | reg_hit(aw_addr_q, REG_IN_A)
                 | reg_hit(aw_addr_q, REG_IN_B) | reg_hit(aw_addr_q, REG_DAC_A)
                 | reg_hit(aw_addr_q, REG_DAC_B);

  // Write channel handshakes and response.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_rdy_q  <= 1'b0;
      w_rdy_q   <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      bvalid_q  <= bvalid_d;
      aw_rdy_q  <= ~aw_have_d & ~bvalid_d;
      w_rdy_q   <= ~w_have_d & ~bvalid_d;
      if (aw_fire) begin
        aw_addr_q <= i_awaddr;
      end
      if (w_fire) begin
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (do_write) begin
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Control register and frame bookkeeping; only byte lane 0 holds control bits.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q      <= CTRL_RESET;
      frm_cnt_q   <= '0;
      last_addr_q <= CH_NONE;
    end else begin
      if (do_write && wr_ctrl && w_strb_q[0]) begin
        ctrl_q <= w_data_q[1:0];
      end
      if (frm_take) begin
        frm_cnt_q   <= frm_cnt_q + 8'h01;
        last_addr_q <= frm_addr;
      end
    end
  end

  // Read data selection.
  wire [31:0] status_word = {16'h0000, frm_cnt_q, 4'h0, last_addr_q, load_act, preset_act};
  wire        rd_ctrl  = reg_hit(i_araddr, REG_CTRL);
  wire        rd_stat  = reg_hit(i_araddr, REG_STATUS);
  wire        rd_ina   = reg_hit(i_araddr, REG_IN_A);
  wire        rd_inb   = reg_hit(i_araddr, REG_IN_B);
  wire        rd_daca  = reg_hit(i_araddr, REG_DAC_A);
  wire        rd_dacb  = reg_hit(i_araddr, REG_DAC_B);
  wire        rd_known = rd_ctrl | rd_stat | rd_ina | rd_inb | rd_daca | rd_dacb;
  wire [31:0] rd_data  = rd_ctrl ? {30'h0, ctrl_q} :
                         rd_stat ? status_word :
                         rd_ina  ? {18'h0, in_a_q} :
                         rd_inb  ? {18'h0, in_b_q} :
                         rd_daca ? {18'h0, dac_a_q} :
                         rd_dacb ? {18'h0, dac_b_q} : 32'h0;

  // Read channel; one read at a time, answered on the same edge that takes the address.
  logic        ar_rdy_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  wire         ar_fire  = i_arvalid & ar_rdy_q;
  wire         rvalid_d = ar_fire | (rvalid_q & ~i_rready);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= RESP_OKAY;
    end else begin
      ar_rdy_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_fire) begin
        rdata_q <= rd_data;
        rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign o_awready = aw_rdy_q;
  assign o_wready  = w_rdy_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_arready = ar_rdy_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;

  // Checks on the link domain.
  a_shift_step: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
    !i_frame_sel_n |=> sr_q[WORD_W-1:1] == $past(sr_q[WORD_W-2:0]))
    else $error("Shift register did not advance by one.");

  a_pin_direct: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
    !i_frame_sel_n |=> sr_q[0] == $past(i_serial_in))
    else $error("Serial bit did not land in bit 0.");

  a_frame_freeze: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
    i_frame_sel_n |=> $stable(sr_q))
    else $error("Shift register moved with frame select high.");

  a_msb_first: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
    !i_frame_sel_n ##1 !i_frame_sel_n |=> sr_q[1] == $past(i_serial_in, 2))
    else $error("Earlier bit is not one place above the later bit.");

  // Checks on the system domain.
  a_chan_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    frm_take && !preset_act && frm_addr == CH_A
    |=> in_a_q == $past(frm_code) && $stable(in_b_q) && ($stable(dac_a_q) || $past(load_act)))
    else $error("Channel A frame did not update only input A.");

  a_addr_none: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    frm_take && !preset_act && frm_addr == CH_NONE |=> $stable(in_a_q) && $stable(in_b_q))
    else $error("Address code 00 changed an input register.");

  a_both_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    frm_take && !preset_act && frm_addr == CH_BOTH
    |=> in_a_q == $past(frm_code) && in_b_q == $past(frm_code))
    else $error("Address code 11 did not write both channels.");

  a_preset_force: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    preset_act |=> in_a_q == $past(preset_val) && in_b_q == $past(preset_val)
                   && dac_a_q == $past(preset_val) && dac_b_q == $past(preset_val))
    else $error("Preset did not force every register.");

  a_preset_pin: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_preset_n [*3] ##0 lvl_s2_q |=> dac_a_q == PRESET_MID && in_b_q == PRESET_MID)
    else $error("Preset pin with high level did not give midscale.");

  a_power_init: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    init_cnt_q == 2'h1 |=> dac_a_q == $past(preset_val) && dac_b_q == $past(preset_val))
    else $error("Power-on preset value missing.");

  // A pin low for three samples has reached the load stage by the third.
  sequence s_load_held;
    !i_dac_load_n [*3] ##0 !preset_act;
  endsequence

  a_load_follow: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_load_held |=> dac_a_q == $past(in_a_q) && dac_b_q == $past(in_b_q))
    else $error("DAC registers did not follow with load low.");

  a_load_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !load_act && !preset_act |=> $stable(dac_a_q) && $stable(dac_b_q))
    else $error("DAC registers changed with load high.");

endmodule

// ==== ddl_pkg.sv ====
package ddl_pkg;

  // Widths of the serial word and of one conversion code.
  localparam int WORD_W = 16;
  localparam int CODE_W = 14;

  // Position of the two channel address bits inside the captured word.
  localparam int ADDR_HI_BIT = 15;
  localparam int ADDR_LO_BIT = 14;

  // Channel address codes carried by the two top bits of a frame.
  localparam logic [1:0] CH_NONE = 2'h0;
  localparam logic [1:0] CH_A    = 2'h1;
  localparam logic [1:0] CH_B    = 2'h2;
  localparam logic [1:0] CH_BOTH = 2'h3;

  // Preset codes chosen by the preset-level pin.
  localparam logic [CODE_W-1:0] PRESET_ZERO = 14'h0000;
  localparam logic [CODE_W-1:0] PRESET_MID  = 14'h2000;

  // Cycles of forced preset after reset, long enough for the level synchroniser to settle.
  localparam logic [1:0] INIT_CYC = 2'h3;

  // Register byte offsets and the number of low address bits they decode.
  localparam int         REG_AW     = 5;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IN_A   = 8'h08;
  localparam logic [7:0] REG_IN_B   = 8'h0c;
  localparam logic [7:0] REG_DAC_A  = 8'h10;
  localparam logic [7:0] REG_DAC_B  = 8'h14;

  // Control register fields and reset value.
  localparam int         CTRL_CAP_EN_BIT = 0;
  localparam int         CTRL_PRESET_BIT = 1;
  localparam logic [1:0] CTRL_RESET      = 2'h1;

  // Status register field positions.
  localparam int ST_PRESET_BIT = 0;
  localparam int ST_LOAD_BIT   = 1;
  localparam int ST_ADDR_LSB   = 2;
  localparam int ST_CNT_LSB    = 8;
  localparam int FRM_CNT_W     = 8;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== ddl_host.sv ====
`timescale 1ns/100ps

// Serial host model for the link pins. The clock idles low between frames.
module ddl_host (
  // Link pins towards the converter.
  output logic o_sclk,
  output logic o_serial_in,
  output logic o_frame_sel_n
);
  // Half of the 80 ns link period.
  localparam int HALF_NS = 40;
  // Offset so that link edges never fall on a system clock edge.
  localparam real SKEW_NS = 1.3;

  // Idle pins: frame select high, clock low.
  initial begin
    o_sclk        = 1'b0;
    o_serial_in   = 1'b0;
    o_frame_sel_n = 1'b1;
  end

  // One bit, set up half a period before the rising edge.
  task automatic bit_out(input logic b);
    o_serial_in = b;
    #(HALF_NS);
    o_sclk = 1'b1;
    #(HALF_NS);
    o_sclk = 1'b0;
  endtask

  // Leading junk bits, then the word MSB first; gap_ns stalls between the two bytes.
  task automatic send_frame(input logic [15:0] word, input int extra, input int gap_ns);
    #(SKEW_NS);
    o_frame_sel_n = 1'b0;
    for (int i = 0; i < extra; i++) bit_out(1'($urandom));
    for (int i = 15; i >= 0; i--) begin
      bit_out(word[i]);
      if (i == 8) #(gap_ns);
    end
    #(HALF_NS);
    o_frame_sel_n = 1'b1;
    // A released line must not keep showing the last bit.
    o_serial_in = ~o_serial_in;
  endtask

  // Clock edges with frame select high; these must not move the shift chain.
  task automatic idle_clocks(input int n);
    #(SKEW_NS);
    for (int i = 0; i < n; i++) bit_out(1'b1);
    o_serial_in = 1'b0;
  endtask

  // A frame without clock edges recaptures the frozen shift contents.
  task automatic empty_frame();
    #(SKEW_NS);
    o_frame_sel_n = 1'b0;
    #(HALF_NS);
    o_frame_sel_n = 1'b1;
  endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end

module tb_top;
  import ddl_pkg::*;
  // One expected bus answer; data is skipped where it is not defined.
  typedef struct {string nm; logic [31:0] data; logic [1:0] resp; logic use_d;} ddl_exp_s;
  logic        clk = 1'b0, rst_b = 1'b0, preset_n = 1'b1, level = 1'b1, load_n = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic        sclk, serial_in, cs_n, awready, wready, bvalid, arready, rvalid;
  logic [13:0] dac_a, dac_b, ina, inb, hold_b;
  logic [1:0]  bresp, rresp;
  int          num_errors = 0, checks_done = 0;
  ddl_exp_s    rq[$], bq[$], me;

  // 200 MHz system clock.
  always #2.5 clk = ~clk;

  ddl_host host (.o_sclk(sclk), .o_serial_in(serial_in), .o_frame_sel_n(cs_n));

  ddl_top #(.ADDR_W(8)) DUT (
    .i_clk(clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_serial_in(serial_in), .i_frame_sel_n(cs_n),
    .i_preset_n(preset_n), .i_preset_level(level), .i_dac_load_n(load_n),
    .o_dac_a(dac_a), .o_dac_b(dac_b),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp));

  // Monitor: each answer taken is compared with the oldest note.
  always @(posedge clk) begin
    if (rvalid && rready && rq.size() > 0) begin
      me = rq.pop_front();
      if (me.use_d) `CHK(me.nm, me.data, rdata)
      `CHK(me.nm, me.resp, rresp)
    end
    if (bvalid && bready && bq.size() > 0) begin
      me = bq.pop_front();
      `CHK(me.nm, me.resp, bresp)
    end
  end

  // Write: address and data offered together, each released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    bq.push_back('{"bresp", 32'h0, er, 1'b0});
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (!(bvalid && bready) && n < 200);
    // A response that never comes counts as a mismatch.
    if (!(bvalid && bready)) num_errors++;
    bready <= 1'b0;
  endtask

  // Read: rready held until the answer is sampled.
  task automatic axi_rd(input logic [7:0] a, input string nm, input logic [31:0] d,
                        input logic [1:0] er, input logic ud);
    int n = 0;
    rq.push_back('{nm, d, er, ud});
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (!(rvalid && rready) && n < 200);
    // A read answer that never comes counts as a mismatch.
    if (!(rvalid && rready)) num_errors++;
    rready <= 1'b0;
  endtask

  // Sends one frame and updates the model; the wait covers the 3-edge capture.
  task automatic frame(input logic [1:0] ad, input logic [13:0] cd, input int ex,
                       input int gap, input logic upd);
    host.send_frame({ad, cd}, ex, gap);
    if (upd && ad[0]) ina = cd;
    if (upd && ad[1]) inb = cd;
    repeat (8) @(posedge clk);
  endtask

  // Both input registers against the model.
  task automatic check_in();
    axi_rd(REG_IN_A, "in_a", 32'(ina), RESP_OKAY, 1'b1);
    axi_rd(REG_IN_B, "in_b", 32'(inb), RESP_OKAY, 1'b1);
  endtask

  task automatic complete_run();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog sized well above the roughly 3000 cycles the sequence needs.
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'hecb2));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    ina = PRESET_MID;
    inb = PRESET_MID;
    `CHK("dac_a", PRESET_MID, dac_a)
    axi_rd(REG_CTRL, "ctrl", 32'(CTRL_RESET), RESP_OKAY, 1'b1);
    check_in();
    axi_rd(8'h1c, "unmapped", 32'h0, RESP_SLVERR, 1'b0);
    axi_wr(8'h1c, 32'hffff_ffff, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'h0000_ffff, RESP_OKAY);
    // Codes 1, 2, 3, 0; one frame has junk bits, one a slow host.
    for (int k = 0; k < 4; k++) begin
      frame(2'(k + 1), 14'($urandom), (k == 2) ? 4 : 0, (k == 1) ? 300 : 0, 1'b1);
      check_in();
      axi_rd(REG_DAC_A, "dac_a_hold", 32'(PRESET_MID), RESP_OKAY, 1'b1);
    end
    // Transparent load, then a frame while it stays low.
    load_n <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("dac_b", inb, dac_b)
    frame(CH_A, 14'($urandom), 0, 0, 1'b1);
    `CHK("dac_a", ina, dac_a)
    load_n <= 1'b1;
    hold_b = inb;
    repeat (4) @(posedge clk);
    frame(CH_B, 14'($urandom), 0, 0, 1'b1);
    `CHK("dac_b_hold", hold_b, dac_b)
    // Code bits 10:9 are 11: five stray shifts would turn this into a both-channel word.
    frame(CH_B, 14'h0655, 0, 0, 1'b1);
    host.idle_clocks(5);
    host.empty_frame();
    repeat (8) @(posedge clk);
    check_in();
    // Capture disabled: a frame must be ignored.
    axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
    frame(CH_BOTH, 14'($urandom), 0, 0, 1'b0);
    check_in();
    // Eight frames were taken so far and the last one addressed channel B.
    axi_rd(REG_STATUS, "status", {16'h0, 8'h8, 6'h2, 2'h0}, RESP_OKAY, 1'b1);
    // Software preset with the level pin high forces midscale everywhere.
    axi_wr(REG_CTRL, 32'h3, RESP_OKAY);
    ina = PRESET_MID;
    inb = PRESET_MID;
    check_in();
    axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
    // Preset at both levels, with load and a frame competing.
    for (int lv = 0; lv < 2; lv++) begin
      level    <= lv[0];
      preset_n <= 1'b0;
      load_n   <= 1'b0;
      ina = lv[0] ? PRESET_MID : PRESET_ZERO;
      inb = ina;
      repeat (6) @(posedge clk);
      `CHK("dac_a_preset", ina, dac_a)
      frame(CH_BOTH, 14'($urandom), 0, 0, 1'b0);
      check_in();
      preset_n <= 1'b1;
      load_n   <= 1'b1;
      repeat (6) @(posedge clk);
      axi_rd(REG_DAC_B, "dac_b_preset", 32'(inb), RESP_OKAY, 1'b1);
    end
    complete_run();
  end
endmodule
